// ==== src/scr_charger_regs.sv ====
// What this block does
// (R1) Current set point is bits 7..12 weighted 128mA up to 8064mA.
// (R2) Other current bits ignored; current never exceeds 8064mA.
// (R3) Voltage set point is bits 4..14 weighted 16mV..16384mV; rest ignored.
// (R4) Voltage set point clamps to at least 1024mV.
// (R5) Voltage set point clamps to at most 19200mV.
// (R6) Alarm word with bit 12..15 set stops charging; others ignored.
// (R7) Mode bits 6, 5, 4 mask power-fail, battery and adapter interrupts.
// (R8) Entering or leaving dropout also requests an interrupt.
// (R9) Host clears interrupts by repeated reads at alert address 0x19.
// (R10) Alert read returns 0x13 and clears our interrupt request.
// (R11) Alert reply arbitrates bitwise; loser keeps request for later.
// (R12) No voltage or current command for 175s stops charging.
// (R13) Every voltage or current command restarts the watchdog.
// (R14) Open thermistor sets its bit, resets charger, clears battery present.
// (R15) Cold bit follows thermistor above 30k and does not affect charging.
// (R16) Hot bit latches below 3k; cleared by removal or reset request.
// (R17) Hot bit stops charging unless overheat_halt_enable clear or underrange set.
// (R18) Underrange bit follows thermistor below 500 ohm.
// (R19) Power-fail, battery or adapter change drives interrupt pin low.
// (R20) Alarm inhibit set by timeout or alarm bits 12,14,15; cleared by removal, reset request, or both voltage and current commands.
// (R21) Thermistor comparators pass two flip-flops before use.
module scr_charger_regs #(
   parameter longint unsigned WDOG_CYCLES = scr_pkg::WDOG_CYCLES
) (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic smb_clk_i,
   input wire logic smb_data_i,
   output logic smb_data_o,
   output logic smb_data_oe_n_o,
   input wire logic power_fail_i,
   input wire logic adapter_detect_flag_i,
   input wire logic dropout_i,
   input wire logic temp_sense_open_i,
   input wire logic temp_sense_cold_i,
   input wire logic hot_pack_i,
   input wire logic temp_sense_underrange_i,
   output logic int_n_o,
   output logic charge_enable_o,
   output logic [scr_pkg::CUR_W-1:0] charge_current_ma_o,
   output logic [scr_pkg::VOLT_W-1:0] charge_voltage_mv_o
);
   import scr_pkg::*;

   localparam int SYNC_W = 9;

   function automatic logic scr_changed(input logic prev, input logic now);
      scr_changed = prev ^ now;
   endfunction

   function automatic logic [VOLT_W-1:0] scr_clamp_mv(input logic [15:0] w);
      logic [VOLT_W-1:0] raw;
      raw = {w[VOLT_MSB:VOLT_LSB], 4'h0};
      if (raw < VOLT_MIN_MV) begin
         scr_clamp_mv = VOLT_MIN_MV;
      end else if (raw > VOLT_MAX_MV) begin
         scr_clamp_mv = VOLT_MAX_MV;
      end else begin
         scr_clamp_mv = raw;
      end
   endfunction

   // ==========================================================
   // Pin synchronisers.
   // ==========================================================
   logic [SYNC_W-1:0] pins_s;
   logic scl_s, sda_s, pf_s, ac_s, drop_s, open_s, cold_s, hot_s, ur_s;

   scr_sync #(.WIDTH(SYNC_W)) u_sync (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .async_i({smb_clk_i, smb_data_i, power_fail_i, adapter_detect_flag_i,
                dropout_i, temp_sense_open_i, temp_sense_cold_i, hot_pack_i,
                temp_sense_underrange_i}),
      .sync_o(pins_s)
   ); // see (R21)

   assign {scl_s, sda_s, pf_s, ac_s, drop_s, open_s, cold_s, hot_s,
           ur_s} = pins_s;

   // ==========================================================
   // Bus framing.
   // ==========================================================
   scr_bus_state_t state_q;
   logic scl_p_q, sda_p_q;
   logic [3:0] bit_cnt_q;
   logic [2:0] byte_idx_q;
   logic [7:0] sh_q, cmd_q, lo_q;
   logic rd_q, alert_q, tx_hi_q, ack_q, sda_oe_n_q;
   logic irq_q;
   logic [15:0] status_w;

   logic start_w, stop_w, scl_rise_w, scl_fall_w, byte_done_w;
   logic wr_hit_w, rd_hit_w, alert_hit_w, ack_w, lose_w, alert_win_w;
   logic commit_w;
   logic [15:0] wr_word_w;
   logic [7:0] tx_byte_w;

   assign start_w = scl_s & sda_p_q & ~sda_s;
   assign stop_w = scl_s & ~sda_p_q & sda_s;
   assign scl_rise_w = scl_s & ~scl_p_q;
   assign scl_fall_w = ~scl_s & scl_p_q;
   assign byte_done_w = scl_fall_w & (state_q == ST_RX) &
                        (bit_cnt_q == BYTE_BITS);
   assign wr_hit_w = (sh_q == DEV_WR_BYTE);
   assign rd_hit_w = (sh_q == DEV_RD_BYTE);
   assign alert_hit_w = (sh_q == ALERT_RD_BYTE) & irq_q; // see (R9)
   assign ack_w = (byte_idx_q == IDX_ADDR) ?
                  (wr_hit_w | rd_hit_w | alert_hit_w) :
                  (~rd_q & (byte_idx_q <= IDX_HI));
   // A released bit read back as low means another replier won.
   assign lose_w = (state_q == ST_TX) & scl_rise_w & sda_oe_n_q &
                   ~sda_s; // see (R11)
   assign alert_win_w = (state_q == ST_TX_ACK) & alert_q &
                        scl_rise_w; // see (R10)
   assign tx_byte_w = alert_q ? ALERT_REPLY : status_w[7:0]; // see (R10)
   assign commit_w = byte_done_w & ~rd_q & (byte_idx_q == IDX_HI);
   assign wr_word_w = {sh_q, lo_q};

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         smb_data_o <= 1'b0;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
         smb_data_o <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         byte_idx_q <= IDX_ADDR;
         sh_q <= 8'h00;
         cmd_q <= 8'h00;
         lo_q <= 8'h00;
         rd_q <= 1'b0;
         alert_q <= 1'b0;
         tx_hi_q <= 1'b0;
         ack_q <= 1'b0;
         sda_oe_n_q <= 1'b1;
      end else if (start_w) begin
         state_q <= ST_RX;
         bit_cnt_q <= 4'h0;
         byte_idx_q <= IDX_ADDR;
         rd_q <= 1'b0;
         alert_q <= 1'b0;
         tx_hi_q <= 1'b0;
         sda_oe_n_q <= 1'b1;
      end else if (stop_w) begin
         state_q <= ST_IDLE;
         sda_oe_n_q <= 1'b1;
      end else begin
         case (state_q)
            ST_RX: begin
               if (scl_rise_w) begin
                  sh_q <= {sh_q[6:0], sda_s};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (byte_done_w) begin
                  state_q <= ack_w ? ST_RX_ACK : ST_IDLE;
                  sda_oe_n_q <= ~ack_w;
                  byte_idx_q <= byte_idx_q + 3'h1;
                  if (byte_idx_q == IDX_ADDR) begin
                     rd_q <= sh_q[0];
                     alert_q <= alert_hit_w;
                  end
                  if (byte_idx_q == IDX_CMD) begin
                     cmd_q <= sh_q;
                  end
                  if (byte_idx_q == IDX_LO) begin
                     lo_q <= sh_q;
                  end
               end
            end
            ST_RX_ACK: begin
               if (scl_fall_w) begin
                  bit_cnt_q <= 4'h0;
                  state_q <= rd_q ? ST_TX : ST_RX;
                  sh_q <= tx_byte_w;
                  sda_oe_n_q <= rd_q ? tx_byte_w[7] : 1'b1;
               end
            end
            ST_TX: begin
               if (lose_w) begin
                  state_q <= ST_IDLE; // see (R11)
               end else if (scl_rise_w) begin
                  sh_q <= {sh_q[6:0], 1'b0};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (scl_fall_w) begin
                  if (bit_cnt_q == BYTE_BITS) begin
                     sda_oe_n_q <= 1'b1;
                     state_q <= ST_TX_ACK;
                  end else begin
                     sda_oe_n_q <= sh_q[7];
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise_w) begin
                  ack_q <= ~sda_s;
               end else if (scl_fall_w) begin
                  if (ack_q & ~alert_q & ~tx_hi_q) begin
                     tx_hi_q <= 1'b1;
                     bit_cnt_q <= 4'h0;
                     sh_q <= status_w[15:8];
                     sda_oe_n_q <= status_w[15];
                     state_q <= ST_TX;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
               sda_oe_n_q <= 1'b1;
            end
         endcase
      end
   end

   // ==========================================================
   // Command registers and charging control.
   // ==========================================================
   logic commit_cur_w, commit_volt_w, commit_alarm_w, commit_mode_w;
   logic por_req_w, por_w, bat_w, removal_w, wd_restart_w, wd_exp_w;
   logic inh_set_w, inh_clr_w, hot_block_w, irq_set_w, charge_en_d;
   logic [15:0] mode_q;
   logic [CUR_W-1:0] cur_ma_q;
   logic [VOLT_W-1:0] volt_mv_q;
   logic cur_or_q, volt_or_q, alarm_stop_q, alarm_inh_q, got_v_q, got_i_q;
   logic hot_q, wd_exp_p_q, bat_p_q, pf_p_q, ac_p_q, drop_p_q;

   assign commit_cur_w = commit_w & (cmd_q == CMD_CURRENT);
   assign commit_volt_w = commit_w & (cmd_q == CMD_VOLTAGE);
   assign commit_alarm_w = commit_w & (cmd_q == CMD_ALARM);
   assign commit_mode_w = commit_w & (cmd_q == CMD_MODE);
   assign por_req_w = commit_mode_w & wr_word_w[MODE_POR_BIT];
   assign bat_w = ~open_s; // see (R14)
   assign por_w = por_req_w | open_s; // see (R14)
   assign removal_w = bat_p_q & ~bat_w;
   assign wd_restart_w = commit_cur_w | commit_volt_w; // see (R13)
   assign inh_set_w = (wd_exp_w & ~wd_exp_p_q) |
                      (commit_alarm_w &
                       (|(wr_word_w & ALARM_INHIBIT_MASK))); // see (R20)
   assign inh_clr_w = removal_w | por_req_w | (got_v_q & got_i_q);
   assign hot_block_w = hot_q & mode_q[MODE_OVERHEAT_HALT_ENABLE_BIT] &
                        ~ur_s; // see (R17)
   assign irq_set_w =
      (scr_changed(pf_p_q, pf_s) & ~mode_q[MODE_PF_MASK_BIT]) |
      (scr_changed(bat_p_q, bat_w) & ~mode_q[MODE_BP_MASK_BIT]) |
      (scr_changed(ac_p_q, ac_s) & ~mode_q[MODE_AC_MASK_BIT]) |
      scr_changed(drop_p_q, drop_s); // see (R7) (R8) (R19)
   // Cold only reports and never gates charging; underrange only overrides the hot block.
   assign charge_en_d = bat_w & ac_s & ~alarm_stop_q & ~alarm_inh_q &
                        ~wd_exp_w & ~hot_block_w; // see (R6) (R12) (R15)
   assign status_w = {ac_s, bat_w, pf_s, alarm_inh_q, ur_s, hot_q, cold_s,
                      open_s, volt_or_q, cur_or_q, 1'b0, 1'b1, 2'b00, 1'b0,
                      ~charge_enable_o}; // see (R15) (R18)

   scr_watchdog #(.TIMEOUT_CYCLES(WDOG_CYCLES)) u_wdog (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .restart_i(wd_restart_w),
      .expired_o(wd_exp_w)
   ); // see (R12)

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_q <= MODE_RESET;
         cur_ma_q <= '0;
         volt_mv_q <= '0;
         cur_or_q <= 1'b0;
         volt_or_q <= 1'b0;
         alarm_stop_q <= 1'b0;
      end else if (por_w) begin
         mode_q <= MODE_RESET;
         cur_ma_q <= '0;
         volt_mv_q <= '0;
         cur_or_q <= 1'b0;
         volt_or_q <= 1'b0;
         alarm_stop_q <= 1'b0;
      end else begin
         if (commit_mode_w) begin
            mode_q <= wr_word_w;
         end
         if (commit_cur_w) begin
            cur_ma_q <= {wr_word_w[CUR_MSB:CUR_LSB], 7'h00}; // see (R1) (R2)
            cur_or_q <= (wr_word_w > CUR_OR_LIMIT);
         end
         if (commit_volt_w) begin
            volt_mv_q <= scr_clamp_mv(wr_word_w); // see (R3) (R4) (R5)
            volt_or_q <= (wr_word_w > VOLT_OR_LIMIT);
         end
         if (commit_alarm_w) begin
            alarm_stop_q <= |(wr_word_w & ALARM_STOP_MASK); // see (R6)
         end
      end
   end

   // Set wins over clear for every latched flag except got_v_q and got_i_q, where clear wins.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         alarm_inh_q <= 1'b0;
         got_v_q <= 1'b0;
         got_i_q <= 1'b0;
         hot_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         alarm_inh_q <= inh_set_w | (alarm_inh_q & ~inh_clr_w); // see (R20)
         got_v_q <= ~inh_set_w & ~inh_clr_w & (got_v_q | commit_volt_w);
         got_i_q <= ~inh_set_w & ~inh_clr_w & (got_i_q | commit_cur_w);
         hot_q <= hot_s | (hot_q & ~removal_w & ~por_req_w); // see (R16)
         irq_q <= irq_set_w | (irq_q & ~alert_win_w); // see (R10)
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wd_exp_p_q <= 1'b0;
         bat_p_q <= 1'b0;
         pf_p_q <= 1'b0;
         ac_p_q <= 1'b0;
         drop_p_q <= 1'b0;
         int_n_o <= 1'b1;
         charge_enable_o <= 1'b0;
         charge_current_ma_o <= '0;
         charge_voltage_mv_o <= '0;
         smb_data_oe_n_o <= 1'b1;
      end else begin
         wd_exp_p_q <= wd_exp_w;
         bat_p_q <= bat_w;
         pf_p_q <= pf_s;
         ac_p_q <= ac_s;
         drop_p_q <= drop_s;
         int_n_o <= ~irq_q; // see (R19)
         charge_enable_o <= charge_en_d;
         charge_current_ma_o <= cur_ma_q;
         charge_voltage_mv_o <= volt_mv_q;
         smb_data_oe_n_o <= sda_oe_n_q;
      end
   end

   // ==========================================================
   // Assertions.
   // ==========================================================
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_alarm_stop;
      commit_alarm_w && (|(wr_word_w & ALARM_STOP_MASK)) && !por_w;
   endsequence

   sequence s_alert_won;
      alert_win_w && !irq_set_w;
   endsequence

   property p_cur_map;
      commit_cur_w && !por_w |=>
         cur_ma_q == {$past(wr_word_w[CUR_MSB:CUR_LSB]), 7'h00};
   endproperty
   a_cur_map: assert property (p_cur_map) // see (R1)
      else $error("current set point does not follow bits 7 to 12");

   property p_cur_max;
      cur_ma_q <= CUR_MAX_MA;
   endproperty
   a_cur_max: assert property (p_cur_max) // see (R2)
      else $error("current set point above its maximum");

   property p_volt_map;
      commit_volt_w && !por_w && (|wr_word_w[VOLT_MSB:10]) &&
         ({wr_word_w[VOLT_MSB:VOLT_LSB], 4'h0} <= VOLT_MAX_MV) |=>
         volt_mv_q == {$past(wr_word_w[VOLT_MSB:VOLT_LSB]), 4'h0};
   endproperty
   a_volt_map: assert property (p_volt_map) // see (R3)
      else $error("voltage set point does not follow bits 4 to 14");

   property p_volt_range;
      commit_volt_w && !por_w |=>
         volt_mv_q >= VOLT_MIN_MV && volt_mv_q <= VOLT_MAX_MV;
   endproperty
   a_volt_range: assert property (p_volt_range) // see (R4) (R5)
      else $error("voltage set point outside its clamp");

   property p_alarm_stop;
      s_alarm_stop |=> ##1 !charge_enable_o;
   endproperty
   a_alarm_stop: assert property (p_alarm_stop) // see (R6)
      else $error("alarm word did not stop charging");

   property p_irq_set;
      irq_set_w |=> irq_q ##1 !int_n_o;
   endproperty
   a_irq_set: assert property (p_irq_set) // see (R19)
      else $error("status change did not pull the interrupt low");

   property p_pf_mask;
      scr_changed(pf_p_q, pf_s) && !mode_q[MODE_PF_MASK_BIT] |=> irq_q;
   endproperty
   a_pf_mask: assert property (p_pf_mask) // see (R7)
      else $error("unmasked power fail change lost");

   property p_irq_clear;
      s_alert_won |=> !irq_q;
   endproperty
   a_irq_clear: assert property (p_irq_clear) // see (R10)
      else $error("won alert reply did not clear the request");

   property p_arb_lose;
      lose_w && !start_w && !stop_w |=>
         state_q == ST_IDLE && sda_oe_n_q ##1 smb_data_oe_n_o;
   endproperty
   a_arb_lose: assert property (p_arb_lose) // see (R11)
      else $error("lost arbitration without releasing data line");

   property p_wdog;
      $rose(wd_exp_w) |-> ##1 !charge_enable_o;
   endproperty
   a_wdog: assert property (p_wdog) // see (R12)
      else $error("watchdog expiry did not stop charging");

   property p_wdog_restart;
      wd_restart_w |=> !wd_exp_w;
   endproperty
   a_wdog_restart: assert property (p_wdog_restart) // see (R13)
      else $error("command did not restart the watchdog");

   property p_open_por;
      open_s |=> cur_ma_q == '0 && volt_mv_q == '0 && mode_q == MODE_RESET;
   endproperty
   a_open_por: assert property (p_open_por) // see (R14)
      else $error("open thermistor did not reset the charger");

   property p_hot_latch;
      hot_q && !removal_w && !por_req_w |=> hot_q;
   endproperty
   a_hot_latch: assert property (p_hot_latch) // see (R16)
      else $error("hot flag dropped without a clearing event");

   property p_overheat_halt_enable;
      hot_block_w |=> !charge_enable_o;
   endproperty
   a_overheat_halt_enable: assert property (p_overheat_halt_enable) // see (R17)
      else $error("hot battery did not stop charging");

endmodule

// ==== include/scr_pkg.sv ====
package scr_pkg;

   // ==========================================================
   // Clock and watchdog timing.
   // ==========================================================
   localparam longint unsigned CLK_HZ = 64'h0000_0000_05F5_E100;
   localparam longint unsigned WDOG_TIME_S = 64'h0000_0000_0000_00AF;
   localparam longint unsigned WDOG_CYCLES = WDOG_TIME_S * CLK_HZ;

   // ==========================================================
   // Bus addresses and command codes.
   // ==========================================================
   localparam logic [7:0] DEV_WR_BYTE = 8'h12;
   localparam logic [7:0] DEV_RD_BYTE = 8'h13;
   localparam logic [7:0] ALERT_RD_BYTE = 8'h19;
   localparam logic [7:0] ALERT_REPLY = 8'h13;
   localparam logic [7:0] CMD_MODE = 8'h12;
   localparam logic [7:0] CMD_STATUS = 8'h13;
   localparam logic [7:0] CMD_CURRENT = 8'h14;
   localparam logic [7:0] CMD_VOLTAGE = 8'h15;
   localparam logic [7:0] CMD_ALARM = 8'h16;

   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [2:0] IDX_ADDR = 3'h0;
   localparam logic [2:0] IDX_CMD = 3'h1;
   localparam logic [2:0] IDX_LO = 3'h2;
   localparam logic [2:0] IDX_HI = 3'h3;

   // ==========================================================
   // Set point fields and limits.
   // ==========================================================
   localparam int CUR_W = 13;
   localparam int VOLT_W = 15;
   localparam int CUR_LSB = 7;
   localparam int CUR_MSB = 12;
   localparam int VOLT_LSB = 4;
   localparam int VOLT_MSB = 14;
   localparam logic [CUR_W-1:0] CUR_MAX_MA = 13'h1F80;
   localparam logic [VOLT_W-1:0] VOLT_MIN_MV = 15'h0400;
   localparam logic [VOLT_W-1:0] VOLT_MAX_MV = 15'h4B00;
   localparam logic [15:0] CUR_OR_LIMIT = 16'h1F80;
   localparam logic [15:0] VOLT_OR_LIMIT = 16'h4B00;
   localparam logic [15:0] ALARM_STOP_MASK = 16'hF000;
   localparam logic [15:0] ALARM_INHIBIT_MASK = 16'hD000;

   // ==========================================================
   // Mode command word fields.
   // ==========================================================
   localparam int MODE_OVERHEAT_HALT_ENABLE_BIT = 1;
   localparam int MODE_POR_BIT = 3;
   localparam int MODE_AC_MASK_BIT = 4;
   localparam int MODE_BP_MASK_BIT = 5;
   localparam int MODE_PF_MASK_BIT = 6;
   localparam logic [15:0] MODE_RESET = 16'h0002;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RX = 3'h1,
      ST_RX_ACK = 3'h2,
      ST_TX = 3'h3,
      ST_TX_ACK = 3'h4
   } scr_bus_state_t;

endpackage

// ==== src/scr_sync.sv ====
module scr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;

   // The first stage is read by the second stage only.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end

endmodule

// ==== src/scr_watchdog.sv ====
module scr_watchdog #(
   parameter longint unsigned TIMEOUT_CYCLES = scr_pkg::WDOG_CYCLES
) (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic restart_i,
   output logic expired_o
);

   localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT_CYCLES - 1);

   logic [CNT_W-1:0] cnt_q;

   // Counts up while no command arrives and holds at expiry.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q <= '0;
         expired_o <= 1'b0;
      end else if (restart_i) begin
         cnt_q <= '0;
         expired_o <= 1'b0;
      end else if (!expired_o) begin
         cnt_q <= cnt_q + CNT_W'(1);
         expired_o <= (cnt_q == LAST);
      end
   end

endmodule

// ==== tb/scr_host_model.sv ====
module scr_host_model (
   input wire logic clock_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import scr_pkg::*;
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic bit_io(input logic b, output logic r);
      repeat (6) @(posedge clock_i);
      sda_low_o <= ~b;
      repeat (4) @(posedge clock_i);
      scl_o <= 1'b1;
      repeat (10) @(posedge clock_i);
      r = sda_i;
      scl_o <= 1'b0;
   endtask
   // Start when s is 1, stop when s is 0; the clock idles high after a stop.
   task automatic cond(input logic s);
      repeat (6) @(posedge clock_i);
      sda_low_o <= ~s;
      repeat (4) @(posedge clock_i);
      scl_o <= 1'b1;
      repeat (10) @(posedge clock_i);
      sda_low_o <= s;
      repeat (10) @(posedge clock_i);
      if (s) begin
         scl_o <= 1'b0;
      end
   endtask
   task automatic byte_io(input logic [7:0] d, input logic ak,
                          output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r[i]);
      end
      bit_io(ak, a);
   endtask
   task automatic wr_word(input logic [7:0] c, input logic [15:0] w);
      logic [7:0] r;
      logic a;
      cond(1'b1);
      byte_io(DEV_WR_BYTE, 1'b1, r, a);
      byte_io(c, 1'b1, r, a);
      byte_io(w[7:0], 1'b1, r, a);
      byte_io(w[15:8], 1'b1, r, a);
      cond(1'b0);
   endtask
   task automatic rd_status(output logic [15:0] s);
      logic [7:0] r;
      logic a;
      cond(1'b1);
      byte_io(DEV_WR_BYTE, 1'b1, r, a);
      byte_io(CMD_STATUS, 1'b1, r, a);
      cond(1'b1);
      byte_io(DEV_RD_BYTE, 1'b1, r, a);
      byte_io(8'hFF, 1'b0, s[7:0], a);
      byte_io(8'hFF, 1'b1, s[15:8], a);
      cond(1'b0);
   endtask
   // A rival reply is pulled onto the wire bit by bit; a low bit wins.
   task automatic alert(input logic [7:0] rival, output logic [7:0] r,
                        output logic a);
      logic x;
      cond(1'b1);
      byte_io(ALERT_RD_BYTE, 1'b1, r, a);
      byte_io(rival, 1'b1, r, x);
      cond(1'b0);
   endtask
endmodule

// ==== tb/tb_scr_charger_regs.sv ====
module tb_scr_charger_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import scr_pkg::*;
   localparam longint unsigned WD = 64'h0000_0000_0000_0BB8;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic pf = 1'b0;
   logic ac = 1'b1;
   logic dro = 1'b0;
   logic op = 1'b0;
   logic cold = 1'b0;
   logic hot = 1'b0;
   logic ur = 1'b0;
   logic scl, sda_low, sda_w, d_o, oe_n, int_n, en, a;
   logic [7:0] r;
   logic [15:0] s;
   logic [CUR_W-1:0] cur;
   logic [VOLT_W-1:0] volt;
   int n_fail = 0;
   int tests_run = 0;
   logic [39:0] rows [9] = '{40'h14_0080_0080, 40'h14_FFFF_1F80,
      40'h14_107F_1000, 40'h14_2A80_0A80, 40'h15_0010_0400,
      40'h15_4B00_4B00, 40'h15_7FFF_4B00, 40'h15_8410_0410,
      40'h15_300F_3000};
   always #5 clock = ~clock;
   assign sda_w = ~sda_low & (oe_n | d_o);
   scr_host_model i_scr_host_model (.clock_i(clock), .sda_i(sda_w),
      .scl_o(scl), .sda_low_o(sda_low));
   scr_charger_regs #(.WDOG_CYCLES(WD)) i_scr_charger_regs (
      .clock_i(clock), .reset_n_i(reset_n), .smb_clk_i(scl),
      .smb_data_i(sda_w), .smb_data_o(d_o), .smb_data_oe_n_o(oe_n),
      .power_fail_i(pf), .adapter_detect_flag_i(ac), .dropout_i(dro),
      .temp_sense_open_i(op), .temp_sense_cold_i(cold), .hot_pack_i(hot),
      .temp_sense_underrange_i(ur), .int_n_o(int_n), .charge_enable_o(en),
      .charge_current_ma_o(cur), .charge_voltage_mv_o(volt));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic feed();
      i_scr_host_model.wr_word(CMD_VOLTAGE, 16'h3000);
      i_scr_host_model.wr_word(CMD_CURRENT, 16'h0A80);
   endtask
   task automatic clr();
      for (int k = 0; k < 6 && int_n === 1'b0; k++) begin
         i_scr_host_model.alert(8'hFF, r, a);
      end
      if (int_n !== 1'b1) begin
         n_fail++;
         end_of_test();
      end
   endtask
   task automatic mode(input logic [15:0] w);
      i_scr_host_model.wr_word(CMD_MODE, w);
   endtask
   initial begin
      repeat (6) @(posedge clock);
      check({1'b0, int_n, en, cur}, 16'h4000);
      check(16'(volt), 16'h0000);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      foreach (rows[i]) begin
         i_scr_host_model.wr_word(rows[i][39:32], rows[i][31:16]);
         s = rows[i][32] ? 16'(volt) : 16'(cur);
         check(s, rows[i][15:0]);
      end
      check(16'(en), 16'h0001);
      $display("set point table done");
      for (int b = 12; b < 16; b++) begin
         i_scr_host_model.wr_word(CMD_ALARM, 16'h0001 << b);
         check(16'(en), 16'h0000);
         i_scr_host_model.wr_word(CMD_ALARM, 16'h0FFF);
         feed();
         check(16'(en), 16'h0001);
      end
      $display("alarm test done");
      repeat (2700) @(posedge clock);
      check(16'(en), 16'h0001);
      repeat (400) @(posedge clock);
      check(16'(en), 16'h0000);
      feed();
      check(16'(en), 16'h0001);
      $display("watchdog test done");
      clr();
      pf <= 1'b1;
      repeat (8) @(posedge clock);
      i_scr_host_model.alert(8'h11, r, a);
      check({7'h00, int_n, r}, 16'h0011);
      i_scr_host_model.alert(8'hFF, r, a);
      check({7'h00, a, r}, 16'h0013);
      check(16'(int_n), 16'h0001);
      mode(16'h0072);
      pf <= 1'b0;
      ac <= 1'b0;
      repeat (8) @(posedge clock);
      check({14'h0000, int_n, en}, 16'h0002);
      dro <= 1'b1;
      repeat (8) @(posedge clock);
      check(16'(int_n), 16'h0000);
      clr();
      mode(16'h0062);
      ac <= 1'b1;
      repeat (8) @(posedge clock);
      check(16'(int_n), 16'h0000);
      clr();
      $display("interrupt test done");
      feed();
      hot <= 1'b1;
      repeat (8) @(posedge clock);
      check(16'(en), 16'h0000);
      mode(16'h0070);
      check(16'(en), 16'h0001);
      mode(16'h0072);
      ur <= 1'b1;
      repeat (8) @(posedge clock);
      check(16'(en), 16'h0001);
      hot <= 1'b0;
      ur <= 1'b0;
      cold <= 1'b1;
      feed();
      i_scr_host_model.rd_status(s);
      check(s & 16'h4F00, 16'h4600);
      check(16'(en), 16'h0000);
      mode(16'h0008);
      feed();
      check(16'(en), 16'h0001);
      op <= 1'b1;
      repeat (8) @(posedge clock);
      check({2'b00, en, cur}, 16'h0000);
      i_scr_host_model.rd_status(s);
      check(s & 16'h4100, 16'h0100);
      $display("thermistor test done");
      end_of_test();
   end
endmodule
